// ### pkg/rps_defs.svh
// Constants of the remappable pin select block: offsets, field positions, masks and reset values.
// Assumes a 12-bit word-aligned register port and 32 remappable pins in four groups of eight.
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

`define RPS_ADDR_W 12
`define RPS_CFG_ADDR 12'h000
`define RPS_IN_PAGE 4'h1
`define RPS_OUT_PAGE 4'h2
`define RPS_NUM_IN 24
`define RPS_NUM_PIN 32
`define RPS_SEL_W 4
`define RPS_LOCK_BIT 13
`define RPS_ONE_WAY_STAT_BIT 14
`define RPS_SESSION_BIT 15
`define RPS_ONE_WAY_BIT 29
`define RPS_IN_SEL_RST 4'hF
`define RPS_OUT_SEL_RST 4'h0
`define RPS_VAR_28 2'h0
`define RPS_VAR_36 2'h1
`define RPS_VAR_44 2'h2
`define RPS_MASK_36UP 32'h20C0_0040
`define RPS_MASK_44ONLY 32'hC020_E0A0
`define RPS_IN_IDLE 24'h41_8308

`endif

// ### pkg/rps_pkg.sv
// Types of the remappable pin select block: bus request and peripheral signal bundles.
// Assumes rps_defs.svh is included by the files that need the constants.
package rps_pkg;

    // One register port request; write and read strobes are never high together.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } rps_bus_req_type;

    // Peripheral outputs that can be routed to pins; the last field is bit 0.
    typedef struct packed {
        logic compare_output_3;
        logic spi2_slave_select;
        logic reference_clock_output;
        logic compare_output_5;
        logic compare_output_4;
        logic comparator3_output;
        logic compare_output_2;
        logic spi2_serial_out;
        logic spi1_serial_out;
        logic comparator2_output;
        logic compare_output_1;
        logic spi1_slave_select;
        logic uart2_request_to_send;
        logic uart1_transmit;
    } rps_periph_out_type;

    // Peripheral inputs fed from pins; the last field is bit 0, in select register order.
    typedef struct packed {
        logic compare_fault_a;
        logic spi2_slave_select;
        logic capture_input_2;
        logic timer5_clock_in;
        logic external_irq_1;
        logic compare_fault_b;
        logic spi2_serial_in;
        logic uart2_clear_to_send;
        logic uart1_receive;
        logic capture_input_5;
        logic capture_input_1;
        logic timer4_clock_in;
        logic external_irq_2;
        logic spi1_serial_in;
        logic uart2_receive;
        logic uart1_clear_to_send;
        logic capture_input_3;
        logic timer3_clock_in;
        logic external_irq_3;
        logic reference_clock_input;
        logic spi1_slave_select;
        logic capture_input_4;
        logic timer2_clock_in;
        logic external_irq_4;
    } rps_periph_in_type;

endpackage : rps_pkg

// ### rtl/rps_pin_remap.sv
// Remappable pin select: input and output routing tables, write lock and one-way lock option.
// Assumes synchronous pin and peripheral signals on ref_clk_i and a system unlock flag from outside.
`timescale 1ns/10ps
`include "rps_defs.svh"

module rps_pin_remap
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Register port.
    input wire rps_pkg::rps_bus_req_type bus_req_i,
    output logic [31:0] bus_rdata_o,
    // System controls and straps.
    input wire logic unlock_ok_i,
    input wire logic [31:0] cfg_word3_i,
    input wire logic [1:0] pkg_variant_i,
    // Pin side.
    input wire logic [31:0] pin_in_i,
    input wire logic [31:0] analog_sel_i,
    output logic [31:0] pin_out_o,
    output logic [31:0] pin_active_o,
    // Peripheral side.
    input wire rps_pkg::rps_periph_out_type periph_out_i,
    output rps_pkg::rps_periph_in_type periph_in_o
);

    logic strap_done_r;
    logic one_way_r;
    logic [1:0] variant_r;
    logic lock_r;
    logic set_once_r;
    logic [23:0][3:0] in_sel_r;
    logic [31:0][3:0] out_sel_r;
    logic [31:0] rdata_r;
    logic [23:0] periph_in_r;
    logic [23:0] periph_in_nxt;
    logic [31:0] pin_out_r;
    logic [31:0] pin_out_nxt;
    logic [31:0] pin_active_r;
    logic [31:0] pin_active_nxt;
    logic [13:0] src_vec;
    logic wr_cfg;
    logic wr_in;
    logic wr_out;

    // True when the address names an input select register.
    function automatic logic is_in_addr(input logic [11:0] a);
        is_in_addr = (a[11:8] == `RPS_IN_PAGE) && (a[7:2] < 6'(`RPS_NUM_IN)) && (a[1:0] == 2'h0);
    endfunction : is_in_addr

    // True when the address names an output select register.
    function automatic logic is_out_addr(input logic [11:0] a);
        is_out_addr = (a[11:8] == `RPS_OUT_PAGE) && (a[7:2] < 6'(`RPS_NUM_PIN)) && (a[1:0] == 2'h0);
    endfunction : is_out_addr

    // Pin group that an input select register draws from.
    function automatic logic [1:0] in_group(input int i);
        if (i < 5)
        begin
            in_group = 2'h0;
        end
        else if (i < 11)
        begin
            in_group = 2'h1;
        end
        else if (i < 19)
        begin
            in_group = 2'h2;
        end
        else
        begin
            in_group = 2'h3;
        end
    endfunction : in_group

    // Whether a pin is bonded out on the strapped package.
    function automatic logic pin_present(input logic [4:0] pin, input logic [1:0] variant);
        logic [31:0] m36;
        logic [31:0] m44;
        m36 = `RPS_MASK_36UP;
        m44 = `RPS_MASK_44ONLY;
        pin_present = !((variant == `RPS_VAR_28) && m36[pin]) && !((variant != `RPS_VAR_44) && m44[pin]);
    endfunction : pin_present

    // Output code decode per group; returns enable and value, reserved codes disable.
    function automatic logic [1:0] route_out(input logic [1:0] g, input logic [3:0] c, input logic [13:0] s);
        route_out = 2'h0;
        case (g)
            2'h0:
            begin
                case (c)
                    4'h1: route_out = {1'b1, s[0]};
                    4'h2: route_out = {1'b1, s[1]};
                    4'h3: route_out = {1'b1, s[2]};
                    4'h5: route_out = {1'b1, s[3]};
                    4'h7: route_out = {1'b1, s[4]};
                    default: route_out = 2'h0;
                endcase
            end
            2'h1:
            begin
                case (c)
                    4'h3: route_out = {1'b1, s[5]};
                    4'h4: route_out = {1'b1, s[6]};
                    4'h5: route_out = {1'b1, s[7]};
                    4'h7: route_out = {1'b1, s[8]};
                    default: route_out = 2'h0;
                endcase
            end
            2'h2:
            begin
                case (c)
                    4'h3: route_out = {1'b1, s[5]};
                    4'h4: route_out = {1'b1, s[6]};
                    4'h5: route_out = {1'b1, s[9]};
                    4'h6: route_out = {1'b1, s[10]};
                    4'h7: route_out = {1'b1, s[11]};
                    default: route_out = 2'h0;
                endcase
            end
            default:
            begin
                case (c)
                    4'h4: route_out = {1'b1, s[12]};
                    4'h5: route_out = {1'b1, s[13]};
                    default: route_out = 2'h0;
                endcase
            end
        endcase
    endfunction : route_out

    // Write decode shared by the lock and the select registers.
    assign wr_cfg = bus_req_i.we && (bus_req_i.addr == `RPS_CFG_ADDR);
    assign wr_in = bus_req_i.we && is_in_addr(bus_req_i.addr);
    assign wr_out = bus_req_i.we && is_out_addr(bus_req_i.addr);
    assign src_vec = periph_out_i;

    // Straps are caught one cycle after reset release; until then the strictest options hold.
    // Later changes on the strap inputs are ignored, as a fuse would be, until the next reset.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            strap_done_r <= 1'b0;
            one_way_r <= 1'b1;
            variant_r <= `RPS_VAR_28;
        end
        else if (!strap_done_r)
        begin
            strap_done_r <= 1'b1;
            one_way_r <= cfg_word3_i[`RPS_ONE_WAY_BIT];
            variant_r <= pkg_variant_i;
        end
    end

    // Write lock; the lock only moves while the system unlock flag is up.
    // Setting is always honoured with the flag; only clearing is blocked by the one-way option.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            lock_r <= 1'b0;
            set_once_r <= 1'b0;
        end
        else if (wr_cfg && unlock_ok_i)
        begin
            if (bus_req_i.wdata[`RPS_LOCK_BIT])
            begin
                lock_r <= 1'b1;
                set_once_r <= 1'b1;
            end
            else if (!(one_way_r && set_once_r))
            begin
                lock_r <= 1'b0;
            end
        end
    end

    // Input selects; locked writes are acknowledged but dropped.
    // The reset value is a reserved code, so no peripheral input listens to a pin until assigned.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            in_sel_r <= {`RPS_NUM_IN{`RPS_IN_SEL_RST}};
        end
        else if (wr_in && !lock_r)
        begin
            in_sel_r[bus_req_i.addr[6:2]] <= bus_req_i.wdata[3:0];
        end
    end

    // Output selects; reset to no connection so nothing drives a pin after reset.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            out_sel_r <= {`RPS_NUM_PIN{`RPS_OUT_SEL_RST}};
        end
        else if (wr_out && !lock_r)
        begin
            out_sel_r[bus_req_i.addr[6:2]] <= bus_req_i.wdata[3:0];
        end
    end

    // Read data stand in the cycle after the strobe only; unmapped addresses read zero.
    // Zeroing the idle cycles lets a shared read bus OR several slaves without a select.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            rdata_r <= 32'h0000_0000;
            if (bus_req_i.re)
            begin
                if (bus_req_i.addr == `RPS_CFG_ADDR)
                begin
                    rdata_r[`RPS_LOCK_BIT] <= lock_r;
                    rdata_r[`RPS_ONE_WAY_STAT_BIT] <= one_way_r;
                    rdata_r[`RPS_SESSION_BIT] <= set_once_r;
                end
                else if (is_in_addr(bus_req_i.addr))
                begin
                    rdata_r[3:0] <= in_sel_r[bus_req_i.addr[6:2]];
                end
                else if (is_out_addr(bus_req_i.addr))
                begin
                    rdata_r[3:0] <= out_sel_r[bus_req_i.addr[6:2]];
                end
            end
        end
    end

    // Input mux: codes with the top bit set or naming an unbonded pin leave the input idle.
    always_comb
    begin
        logic [3:0] code;
        logic [4:0] pin;
        code = 4'h0;
        pin = 5'h00;
        periph_in_nxt = `RPS_IN_IDLE;
        for (int i = 0; i < `RPS_NUM_IN; i++)
        begin
            code = in_sel_r[i];
            pin = {in_group(i), code[2:0]};
            if (!code[3] && pin_present(pin, variant_r))
            begin
                periph_in_nxt[i] = pin_in_i[pin];
            end
        end
    end

    // Output mux: a pin is taken over only by a valid code on a bonded, non-analog pin.
    // Analog mode is tested last so that it always wins, whatever code is stored.
    always_comb
    begin
        logic [1:0] rt;
        rt = 2'h0;
        pin_out_nxt = 32'h0000_0000;
        pin_active_nxt = 32'h0000_0000;
        for (int p = 0; p < `RPS_NUM_PIN; p++)
        begin
            rt = route_out(2'(p >> 3), out_sel_r[p], src_vec);
            pin_active_nxt[p] = rt[1] && pin_present(5'(p), variant_r) && !analog_sel_i[p];
            pin_out_nxt[p] = rt[0] && pin_active_nxt[p];
        end
    end

    // Routed data are registered, which costs one cycle of latency but keeps outputs glitch free.
    // Inputs and outputs share this stage, so both directions see the same delay.
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            periph_in_r <= `RPS_IN_IDLE;
            pin_out_r <= 32'h0000_0000;
            pin_active_r <= 32'h0000_0000;
        end
        else
        begin
            periph_in_r <= periph_in_nxt;
            pin_out_r <= pin_out_nxt;
            pin_active_r <= pin_active_nxt;
        end
    end

    assign bus_rdata_o = rdata_r;
    assign periph_in_o = periph_in_r;
    assign pin_out_o = pin_out_r;
    assign pin_active_o = pin_active_r;

    // Checks on the routing tables and the lock behaviour.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_locked_wr;
        (wr_in || wr_out) && lock_r;
    endsequence

    sequence s_unlocked_out_wr;
        wr_out && !lock_r;
    endsequence

    sequence s_unlocked_in_wr;
        wr_in && !lock_r;
    endsequence

    a_locked_write_dropped: assert property (s_locked_wr |=> $stable(in_sel_r) && $stable(out_sel_r))
        else $error("Select register changed while locked.");
    a_out_write_lands: assert property (s_unlocked_out_wr |=>
        out_sel_r[$past(bus_req_i.addr[6:2])] == $past(bus_req_i.wdata[3:0]))
        else $error("Unlocked output select write was lost.");
    a_reset_no_route: assert property ($rose(reset_n_i) |-> out_sel_r == '0 ##1 pin_active_o == '0)
        else $error("Pins routed right after reset.");
    a_lock_needs_key: assert property (!unlock_ok_i |=> $stable(lock_r))
        else $error("Lock moved without the unlock flag.");
    a_one_way_hold: assert property (one_way_r && set_once_r && lock_r |=> lock_r [*2])
        else $error("Lock cleared under the one-way option.");
    a_lock_readback: assert property (bus_req_i.re && bus_req_i.addr == `RPS_CFG_ADDR |=>
        bus_rdata_o[`RPS_LOCK_BIT] == $past(lock_r))
        else $error("Lock bit readback wrong.");
    a_strap_default: assert property ($rose(reset_n_i) |-> one_way_r)
        else $error("One-way option not on before straps are caught.");

    // Routing checks use the first pin of each group, where every code is walked; the reserved code check uses pin 1.
    a_route_uart1: assert property (out_sel_r[0] == 4'h1 && !analog_sel_i[0] |=>
        pin_active_o[0] && pin_out_o[0] == $past(src_vec[0]))
        else $error("Group one pin does not carry the uart transmit.");
    a_route_spi2: assert property (out_sel_r[8] == 4'h4 && !analog_sel_i[8] |=>
        pin_active_o[8] && pin_out_o[8] == $past(src_vec[6]))
        else $error("Group two pin does not carry spi2 data.");
    a_route_refclk: assert property (out_sel_r[16] == 4'h7 && !analog_sel_i[16] |=>
        pin_active_o[16] && pin_out_o[16] == $past(src_vec[11]))
        else $error("Group three pin does not carry the reference clock.");
    a_route_ss2: assert property (out_sel_r[24] == 4'h4 && !analog_sel_i[24] |=>
        pin_active_o[24] && pin_out_o[24] == $past(src_vec[12]))
        else $error("Group four pin does not carry spi2 select.");
    a_reserved_out: assert property (out_sel_r[1] inside {4'h0, 4'h4, 4'h6} |=> !pin_active_o[1])
        else $error("Reserved output code drives a pin.");
    a_analog_wins: assert property (analog_sel_i[0] |=> !pin_active_o[0])
        else $error("Remap overrode an analog pin.");

    // Input checks watch the selects that are walked through every code, one per group.
    a_in_group_one: assert property (in_sel_r[3] == 4'h1 |=> periph_in_o[3] == $past(pin_in_i[1]))
        else $error("Group one input mux wrong.");
    a_in_group_two: assert property (in_sel_r[9] == 4'h4 |=> periph_in_o[9] == $past(pin_in_i[12]))
        else $error("Group two input mux wrong.");
    a_in_group_three: assert property (in_sel_r[15] == 4'h3 |=> periph_in_o[15] == $past(pin_in_i[19]))
        else $error("Group three input mux wrong.");
    a_in_group_four: assert property (in_sel_r[22] == 4'h2 |=> periph_in_o[22] == $past(pin_in_i[26]))
        else $error("Group four input mux wrong.");
    a_in_reserved: assert property (in_sel_r[3][3] |=> periph_in_o[3] == 1'b1)
        else $error("Reserved input code did not idle the input.");
    a_absent_pin: assert property (variant_r == `RPS_VAR_28 && in_sel_r[3] == 4'h6 |=> periph_in_o[3] == 1'b1)
        else $error("Absent pin reached a peripheral input.");
    a_in_write_lands: assert property (s_unlocked_in_wr |=>
        in_sel_r[$past(bus_req_i.addr[6:2])] == $past(bus_req_i.wdata[3:0]))
        else $error("Unlocked input select write was lost.");

    // Lock, read port and package checks.
    a_two_way_clear: assert property (wr_cfg && unlock_ok_i && !one_way_r &&
        !bus_req_i.wdata[`RPS_LOCK_BIT] |=> !lock_r)
        else $error("Lock not cleared with the one-way option off.");
    a_session_marks: assert property (lock_r |-> set_once_r)
        else $error("Lock set without marking the session.");
    a_rdata_idle: assert property (!bus_req_i.re |=> bus_rdata_o == 32'h0000_0000)
        else $error("Read data stood outside the cycle after a read.");
    a_absent_out: assert property (variant_r == `RPS_VAR_28 |=> pin_active_o[7:5] == 3'h0)
        else $error("Absent pin was driven by the remap.");

endmodule : rps_pin_remap

// ### dv/rps_far_model.sv
// Far side model of the remappable pin select block: the pin levels and the peripheral outputs.
// Assumes the bench flips phase_i to swap every level to its inverse.
`timescale 1ns/10ps

module rps_far_model
(
    // Pattern control.
    input wire logic phase_i,
    // Levels seen by the block.
    output logic [31:0] pin_lvl_o,
    output rps_pkg::rps_periph_out_type periph_lvl_o
);

    // Mixed patterns, so that a wrong pin or source index shows up as a wrong level in one phase.
    assign pin_lvl_o = phase_i ? 32'h5A3C_A5C3 : 32'hA5C3_5A3C;
    assign periph_lvl_o = phase_i ? 14'h1555 : 14'h2AAA;

endmodule : rps_far_model

// ### dv/rps_pin_remap_tb.sv
// Testbench of the remappable pin select block: register port tasks, routing tables and lock scenarios.
// Assumes the far side model and outputs that settle one edge after their cause.
`timescale 1ns/10ps

module rps_pin_remap_tb;

    // Source index plus one for codes 0 to 7 of each output group; zero means no connection.
    localparam logic [31:0] OUT_TAB [4] = '{32'h5040_3210, 32'h9087_6000, 32'hCBA7_6000, 32'h00ED_0000};
    // One input per group whose idle level is one, so a reserved code is told apart from a low pin.
    localparam int IN_IDX [4] = '{3, 9, 15, 22};
    localparam logic [31:0] IDLE_IN = 32'h0041_8308;

    logic ref_clk_i;
    logic reset_n_i;
    rps_pkg::rps_bus_req_type bus_req;
    logic [31:0] rdata;
    logic unlock_ok;
    logic [31:0] cfg_word3;
    logic [1:0] variant;
    logic [31:0] pins;
    logic [31:0] analog_sel;
    logic [31:0] pin_out;
    logic [31:0] pin_act;
    rps_pkg::rps_periph_out_type pouts;
    rps_pkg::rps_periph_in_type pin_feed;
    logic phase;
    logic [31:0] rd;
    int num_errors;
    int n_checks;
    int cycles;

    rps_pin_remap DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req), .bus_rdata_o(rdata),
        .unlock_ok_i(unlock_ok), .cfg_word3_i(cfg_word3), .pkg_variant_i(variant), .pin_in_i(pins),
        .analog_sel_i(analog_sel), .pin_out_o(pin_out), .pin_active_o(pin_act), .periph_out_i(pouts),
        .periph_in_o(pin_feed));

    rps_far_model FAR (.phase_i(phase), .pin_lvl_o(pins), .periph_lvl_o(pouts));

    // Free running clock at 125 MHz.
    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // A hang is cut short well above the fewer than two thousand cycles the scenarios need.
    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus_write(input logic [11:0] addr, input logic [31:0] data);
        @(posedge ref_clk_i);
        bus_req <= '{addr: addr, wdata: data, we: 1'b1, re: 1'b0};
        @(posedge ref_clk_i);
        bus_req <= '0;
    endtask : bus_write

    // Read data stand only in the cycle after the read edge, so they are taken just after that edge.
    task automatic bus_read(input logic [11:0] addr, output logic [31:0] data);
        @(posedge ref_clk_i);
        bus_req <= '{addr: addr, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge ref_clk_i);
        bus_req <= '0;
        #1;
        data = rdata;
    endtask : bus_read

    task automatic settle();
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : settle

    task automatic set_phase(input logic ph);
        @(posedge ref_clk_i);
        phase <= ph;
    endtask : set_phase

    // Straps are caught once after release, so each package variant needs its own reset.
    task automatic do_reset(input logic [31:0] cfg, input logic [1:0] var_sel);
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        cfg_word3 <= cfg;
        variant <= var_sel;
        unlock_ok <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        settle();
        check("pin_active", pin_act, 32'h0);
        check("pin_out", pin_out, 32'h0);
        check("periph_in", 32'(pin_feed), IDLE_IN);
        check("rdata_idle", rdata, 32'h0);
        bus_read(12'h200, rd);
        check("out_sel_reset", rd, 32'h0);
    endtask : do_reset

    // Every code of every output group, on the first pin of the group.
    task automatic run_outputs(input logic [31:0] absent);
        logic [3:0] src;
        logic on;
        for (int g = 0; g < 4; g++)
        begin
            for (int c = 0; c < 16; c++)
            begin
                src = (c < 8) ? OUT_TAB[g][4*c +: 4] : 4'h0;
                on = (src != 4'h0) && !absent[g*8];
                set_phase(c[0]);
                bus_write(12'h200 + 12'(32*g), 32'(c));
                settle();
                check("pin_active", 32'(pin_act[g*8]), 32'(on));
                check("pin_out", 32'(pin_out[g*8]), on ? 32'(pouts[src - 4'h1]) : 32'h0);
            end
        end
    endtask : run_outputs

    // Every code of one input per group, in both phases of the pin pattern.
    task automatic run_inputs(input logic [31:0] absent);
        logic exp_bit;
        for (int g = 0; g < 4; g++)
        begin
            for (int c = 0; c < 16; c++)
            begin
                bus_write(12'h100 + 12'(4*IN_IDX[g]), 32'(c));
                for (int ph = 0; ph < 2; ph++)
                begin
                    set_phase(ph[0]);
                    settle();
                    exp_bit = (c < 8 && !absent[g*8 + c]) ? pins[g*8 + c] : 1'b1;
                    check("periph_in", 32'(pin_feed[IN_IDX[g]]), 32'(exp_bit));
                end
            end
        end
    endtask : run_inputs

    // Main sequence.
    initial
    begin
        reset_n_i = 1'b0;
        bus_req = '0;
        unlock_ok = 1'b0;
        cfg_word3 = 32'hFFFF_FFFF;
        variant = 2'h2;
        analog_sel = 32'h0;
        phase = 1'b0;
        num_errors = 0;
        n_checks = 0;
        cycles = 0;
        // Unprogrammed configuration word on the largest package.
        do_reset(32'hFFFF_FFFF, 2'h2);
        bus_read(12'h000, rd);
        check("config", rd, 32'h0000_4000);
        bus_read(12'h100, rd);
        check("in_sel_reset", rd, 32'h0000_000F);
        bus_read(12'h300, rd);
        check("unmapped", rd, 32'h0);
        run_outputs(32'h0);
        run_inputs(32'h0);
        // An analog pin is never taken by the remap.
        bus_write(12'h200, 32'h1);
        @(posedge ref_clk_i);
        analog_sel <= 32'h0000_0001;
        settle();
        check("analog_pin", 32'(pin_act[0]), 32'h0);
        @(posedge ref_clk_i);
        analog_sel <= 32'h0;
        settle();
        check("digital_pin", 32'(pin_act[0]), 32'h1);
        // Lock write without the unlock sequence is refused.
        bus_write(12'h000, 32'h0000_2000);
        bus_read(12'h000, rd);
        check("lock_refused", 32'(rd[13]), 32'h0);
        @(posedge ref_clk_i);
        unlock_ok <= 1'b1;
        bus_write(12'h000, 32'h0000_2000);
        bus_read(12'h000, rd);
        check("lock_set", 32'(rd[15:13]), 32'h7);
        // Locked writes complete but change nothing.
        bus_write(12'h200, 32'h5);
        bus_read(12'h200, rd);
        check("out_sel_locked", rd, 32'h1);
        bus_write(12'h100, 32'h2);
        bus_read(12'h100, rd);
        check("in_sel_locked", rd, 32'h0000_000F);
        settle();
        check("pin_out_locked", 32'(pin_out[0]), 32'(pouts[0]));
        // With the one-way option the lock cannot be cleared.
        bus_write(12'h000, 32'h0);
        bus_read(12'h000, rd);
        check("lock_kept", 32'(rd[13]), 32'h1);
        // Only a reset clears it; now one-way off and the smallest package.
        do_reset(32'h0, 2'h0);
        bus_read(12'h000, rd);
        check("config_after_reset", 32'(rd[15:13]), 32'h0);
        run_outputs(32'hE0E0_E0E0);
        run_inputs(32'hE0E0_E0E0);
        @(posedge ref_clk_i);
        unlock_ok <= 1'b1;
        bus_write(12'h000, 32'h0000_2000);
        bus_write(12'h000, 32'h0);
        bus_read(12'h000, rd);
        check("lock_cleared", 32'(rd[13]), 32'h0);
        bus_write(12'h204, 32'h4);
        bus_read(12'h204, rd);
        check("out_sel_open", rd, 32'h4);
        // A reserved code is stored but drives nothing, and an unbonded pin is never taken.
        bus_write(12'h214, 32'h1);
        settle();
        check("reserved_pin", 32'(pin_act[1]), 32'h0);
        check("absent_pin", 32'(pin_act[5]), 32'h0);
        close_out();
    end

endmodule : rps_pin_remap_tb
